// ==== hdl/rib_top.sv ====
// Purpose: band classification, speed caps, drive and actuator inhibit
// Assumes: measured percent values arrive from an analog front end in
//          another domain; drive_active_i comes from local logic
// Notes: power cycle equals arst_n_i; latched trips clear only there
// Functional notes
// - input A classified into four bands
// - input B has own three thresholds
// - ten kilohm or open reads 100 percent
// - shorted terminals read 0 percent
// - thresholds 0 to 100 in 1 steps
// - per-band speed limit caps drive speed
// - zero speed limit fully inhibits drive
// - latch setting per input, zero limits only
// - latched trip holds until power cycle
// - non-latching drive resumes when condition clears
// - input A latched trip flashes six bars
// - input B shows charging while its zero limit is latch-enabled
// - band accepted after programmable debounce time
// - seat reversal: A at 0V reverses
// - seat reversal off leaves direction alone
// - alarm enables for charger, A, B
// - only bands 0 and 3 gate actuators
// - channel one eight yes flags block moves
// - no flag leaves direction unaffected
// - channel two has identical eight flags
// - optional sampling only at drive entry
`timescale 1ns/1ns
`include "rib_consts.svh"
module rib_top import rib_pkg::*; #(
   parameter int STEP_CYC = (`RIB_CLK_HZ / 1000) * `RIB_DEB_STEP_MS // cycles per 100 ms
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic [6:0] pct_a_i,
   input wire logic [6:0] pct_b_i,
   input wire logic charger_i,
   input wire logic drive_active_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [6:0] speed_cap_o,
   output logic drive_inhibit_o,
   output logic gauge_flash_six_o,
   output logic gauge_charging_o,
   output logic seat_reverse_o,
   output logic fwd_rate_sel_o,
   output logic alarm_o,
   output logic [1:0] act_up_block_o,
   output logic [1:0] act_down_block_o
);
   // ==========================================================
   // registers and shared signals
   logic [31:0] thr_reg [2];      // lower/middle/upper per input
   logic [31:0] spd_reg [2];      // speed limit per band per input
   logic [31:0] cfg_reg;          // mode bits and debounce steps
   logic [31:0] act_reg;          // actuator yes/no flags
   logic aw_got_reg, w_got_reg;   // write halves captured
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;
   logic [31:0] rd_word;          // read mux result
   logic rd_hit;                  // read address mapped
   logic chg_meta_reg, chg_sync_reg;
   logic drv_d_reg;               // drive active one cycle late
   logic [1:0] trip_reg;          // latched drive trips
   rib_band_t stable_band [2];    // debounced band per input
   rib_band_t eff_band [2];       // band used for drive limits
   rib_pct_t limit [2];           // selected band limit
   rib_pct_t pct_now [2];         // synchronised, clamped percent
   logic [1:0] inh;               // zero-limit inhibit per input

   // ==========================================================
   // helper functions
   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] rib_merge(input logic [31:0] old,
         input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : rib_merge

   // saturate each byte's percent field at 100
   function automatic logic [31:0] rib_clamp(input logic [31:0] v);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 7] = (v[8*i +: 7] > `RIB_PCT_MAX) ? `RIB_PCT_MAX : v[8*i +: 7];
      end
      return r;
   endfunction : rib_clamp

   // ==========================================================
   // axi4-lite write channel
   // handshakes are combinational; ce low stalls every channel
   assign s_axi_awready = ce_i & ~aw_got_reg & ~s_axi_bvalid;
   assign s_axi_wready = ce_i & ~w_got_reg & ~s_axi_bvalid;
   assign do_write = ce_i & aw_got_reg & w_got_reg & ~s_axi_bvalid;

   // capture address and data in either order, answer after both
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RIB_RESP_OK;
      end else if (ce_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // status is read-only, so writes there also fail
            s_axi_bresp <= ({aw_addr_reg[7:2], 2'b00} > `RIB_OFF_ACT) ?
                           `RIB_RESP_ERR : `RIB_RESP_OK;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register file updates
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         thr_reg[0] <= `RIB_THR_RST;
         thr_reg[1] <= `RIB_THR_RST;
         spd_reg[0] <= `RIB_SPD_RST;
         spd_reg[1] <= `RIB_SPD_RST;
         cfg_reg <= `RIB_CFG_RST;
         act_reg <= `RIB_ACT_RST;
      end else if (do_write) begin
         unique case ({aw_addr_reg[7:2], 2'b00})
            `RIB_OFF_THR_A: thr_reg[0] <= rib_clamp(rib_merge(thr_reg[0], w_data_reg,
                                        w_strb_reg)) & `RIB_THR_MASK;
            `RIB_OFF_THR_B: thr_reg[1] <= rib_clamp(rib_merge(thr_reg[1], w_data_reg,
                                        w_strb_reg)) & `RIB_THR_MASK;
            `RIB_OFF_SPD_A: spd_reg[0] <= rib_clamp(rib_merge(spd_reg[0], w_data_reg,
                                        w_strb_reg));
            `RIB_OFF_SPD_B: spd_reg[1] <= rib_clamp(rib_merge(spd_reg[1], w_data_reg,
                                        w_strb_reg));
            `RIB_OFF_CFG: begin
               cfg_reg <= rib_merge(cfg_reg, w_data_reg, w_strb_reg) & `RIB_CFG_MASK;
            end
            `RIB_OFF_ACT: act_reg <= rib_merge(act_reg, w_data_reg, w_strb_reg)
                                     & 32'h0000_ffff;
            default: ; // unmapped or read-only: nothing stored
         endcase
      end
   end

   // ==========================================================
   // axi4-lite read channel
   assign s_axi_arready = ce_i & ~s_axi_rvalid;

   // read mux: status shows live band, trip and output state
   always_comb begin
      rd_hit = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         `RIB_OFF_THR_A: rd_word = thr_reg[0];
         `RIB_OFF_THR_B: rd_word = thr_reg[1];
         `RIB_OFF_SPD_A: rd_word = spd_reg[0];
         `RIB_OFF_SPD_B: rd_word = spd_reg[1];
         `RIB_OFF_CFG: rd_word = cfg_reg;
         `RIB_OFF_ACT: rd_word = act_reg;
         `RIB_OFF_STAT: rd_word = {15'h0000, seat_reverse_o, drive_inhibit_o,
                                   speed_cap_o, 2'h0, trip_reg, stable_band[1],
                                   stable_band[0]};
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RIB_RESP_OK;
      end else if (ce_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `RIB_RESP_OK : `RIB_RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // pin synchronisers and drive-entry edge
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chg_meta_reg <= 1'b0;
         chg_sync_reg <= 1'b0;
         drv_d_reg <= 1'b0;
      end else if (ce_i) begin
         chg_meta_reg <= charger_i;
         chg_sync_reg <= chg_meta_reg;
         drv_d_reg <= drive_active_i;
      end
   end

   // ==========================================================
   // per-input classification, debounce and drive-entry sampling
   for (genvar g = 0; g < 2; g++) begin : g_in
      logic [6:0] meta_reg, sync_reg;  // two-stage percent synchroniser
      rib_band_t raw_band;             // band of the current sample
      rib_band_t cand_reg;             // band being timed
      rib_band_t stab_reg;             // accepted band
      rib_band_t held_reg;             // band frozen at drive entry
      logic [21:0] sub_reg;            // cycles within a 100 ms step
      logic [5:0] step_reg;            // completed steps
      logic [5:0] deb_steps;           // programmed steps, 1..40
      rib_pct_t lo, mid, hi;

      // a multi-bit sample may tear while changing; the debounce
      // below only accepts a band that holds for whole steps
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            meta_reg <= 7'h00;
            sync_reg <= 7'h00;
         end else if (ce_i) begin
            meta_reg <= (g == 0) ? pct_a_i : pct_b_i;
            sync_reg <= meta_reg;
         end
      end

      // above 100 means ten kilohm or open: reads as 100; short reads 0
      assign pct_now[g] = (sync_reg > `RIB_PCT_MAX) ? `RIB_PCT_MAX : sync_reg;
      assign lo = thr_reg[g][6:0];
      assign mid = thr_reg[g][14:8];
      assign hi = thr_reg[g][22:16];

      // band rises with percent
      always_comb begin
         if (pct_now[g] < lo) begin
            raw_band = 2'h0;
         end else if (pct_now[g] <= mid) begin
            raw_band = 2'h1;
         end else if (pct_now[g] <= hi) begin
            raw_band = 2'h2;
         end else begin
            raw_band = 2'h3;
         end
      end

      // clamp the step count so a zero write still debounces
      always_comb begin
         deb_steps = cfg_reg[`RIB_CFG_DEB + 8*g +: 6];
         if (deb_steps < `RIB_DEB_MIN) begin
            deb_steps = `RIB_DEB_MIN;
         end else if (deb_steps > `RIB_DEB_MAX) begin
            deb_steps = `RIB_DEB_MAX;
         end
      end

      // any change of the raw band restarts the stability timer
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            cand_reg <= 2'h0;
            stab_reg <= 2'h0;
            sub_reg <= 22'h000000;
            step_reg <= 6'h00;
         end else if (ce_i) begin
            if (raw_band != cand_reg) begin
               cand_reg <= raw_band;
               sub_reg <= 22'h000000;
               step_reg <= 6'h00;
            end else if (stab_reg != cand_reg) begin
               if (sub_reg == 22'(STEP_CYC - 1)) begin
                  sub_reg <= 22'h000000;
                  if (step_reg + 6'h01 >= deb_steps) begin
                     stab_reg <= cand_reg;
                     step_reg <= 6'h00;
                  end else begin
                     step_reg <= step_reg + 6'h01;
                  end
               end else begin
                  sub_reg <= sub_reg + 22'h000001;
               end
            end
         end
      end

      // hold the band seen in the cycle drive was entered
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            held_reg <= 2'h0;
         end else if (ce_i && !drv_d_reg) begin
            held_reg <= stab_reg;
         end
      end

      assign stable_band[g] = stab_reg;
      assign eff_band[g] = (cfg_reg[`RIB_CFG_ENTRY + g] && drv_d_reg) ? held_reg
                           : stab_reg;
      assign limit[g] = spd_reg[g][8*eff_band[g] +: 7];
      assign inh[g] = (limit[g] == 7'h00);
   end

   // ==========================================================
   // latched trips: only a power cycle (reset) clears them
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trip_reg <= 2'b00;
      end else if (ce_i) begin
         trip_reg <= trip_reg | (inh & cfg_reg[`RIB_CFG_LATCH +: 2]);
      end
   end

   // ==========================================================
   // drive, gauge, seat and alarm outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         speed_cap_o <= 7'h00;
         drive_inhibit_o <= 1'b1;
         gauge_flash_six_o <= 1'b0;
         gauge_charging_o <= 1'b0;
         seat_reverse_o <= 1'b0;
         fwd_rate_sel_o <= 1'b0;
         alarm_o <= 1'b0;
      end else if (ce_i) begin
         // non-latching inputs release as soon as the limit is nonzero
         drive_inhibit_o <= |inh | |trip_reg;
         if (|inh || |trip_reg) begin
            speed_cap_o <= 7'h00;
         end else begin
            speed_cap_o <= (limit[0] < limit[1]) ? limit[0] : limit[1];
         end
         gauge_flash_six_o <= trip_reg[0];
         gauge_charging_o <= cfg_reg[`RIB_CFG_LATCH + 1] & inh[1];
         // direction flip uses input A at 0 percent, the tied-to-0V case
         seat_reverse_o <= cfg_reg[`RIB_CFG_SEAT] && pct_now[0] == 7'h00;
         fwd_rate_sel_o <= cfg_reg[`RIB_CFG_SEAT] && pct_now[0] == 7'h00;
         // an input counts as active while its band limits speed
         alarm_o <= (cfg_reg[`RIB_CFG_ALM_CHG] & chg_sync_reg) |
                    (cfg_reg[`RIB_CFG_ALM] & (limit[0] != `RIB_PCT_MAX)) |
                    (cfg_reg[`RIB_CFG_ALM + 1] & (limit[1] != `RIB_PCT_MAX));
      end
   end

   // ==========================================================
   // actuator gating: flags per channel {down[3:0], up[3:0]},
   // each nibble {B band3, B band0, A band3, A band0}
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         act_up_block_o <= 2'b00;
         act_down_block_o <= 2'b00;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            // middle bands never match, so they never block
            act_up_block_o[c] <=
               (act_reg[8*c + 0] && stable_band[0] == 2'h0) ||
               (act_reg[8*c + 1] && stable_band[0] == 2'h3) ||
               (act_reg[8*c + 2] && stable_band[1] == 2'h0) ||
               (act_reg[8*c + 3] && stable_band[1] == 2'h3);
            act_down_block_o[c] <=
               (act_reg[8*c + 4] && stable_band[0] == 2'h0) ||
               (act_reg[8*c + 5] && stable_band[0] == 2'h3) ||
               (act_reg[8*c + 6] && stable_band[1] == 2'h0) ||
               (act_reg[8*c + 7] && stable_band[1] == 2'h3);
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   thr_range_a: assert property (thr_reg[0][6:0] <= `RIB_PCT_MAX &&
         thr_reg[1][22:16] <= `RIB_PCT_MAX) else $error("threshold above 100");
   band_low_a: assert property (pct_now[0] < thr_reg[0][6:0] |->
         g_in[0].raw_band == 2'h0) else $error("band A below lower not 0");
   band_high_a: assert property (pct_now[1] > thr_reg[1][22:16] |->
         g_in[1].raw_band == 2'h3) else $error("band B above upper not 3");
   deb_wait_a: assert property (ce_i && g_in[0].raw_band != g_in[0].cand_reg |=>
         $stable(stable_band[0])) else $error("band accepted without debounce");
   zero_inh_a: assert property (ce_i && inh[0] |=> drive_inhibit_o &&
         speed_cap_o == 7'h00) else $error("zero limit did not inhibit");
   trip_hold_a: assert property (trip_reg[0] |=> trip_reg[0] && drive_inhibit_o)
         else $error("latched trip released");
   release_a: assert property (ce_i && inh == 2'b00 && trip_reg == 2'b00 |=>
         !drive_inhibit_o) else $error("non-latching inhibit stuck");
   cap_min_a: assert property (ce_i && inh == 2'b00 && trip_reg == 2'b00 |=>
         speed_cap_o <= $past(limit[0]) && speed_cap_o <= $past(limit[1]))
         else $error("speed cap above a band limit");
   seat_off_a: assert property (ce_i && !cfg_reg[`RIB_CFG_SEAT] |=> !seat_reverse_o)
         else $error("seat reversal while disabled");
   act_mid_a: assert property (ce_i && stable_band[0] inside {2'h1, 2'h2} &&
         stable_band[1] inside {2'h1, 2'h2} |=> act_up_block_o == 2'b00 &&
         act_down_block_o == 2'b00) else $error("middle band blocked actuator");
   bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
         else $error("write response dropped early");

   trip_seen_c: cover property (ce_i && inh[0] && cfg_reg[`RIB_CFG_LATCH] ##1 trip_reg[0]);
   band_move_c: cover property ($changed(stable_band[1]));
   act_block_c: cover property (act_down_block_o[1]);
   entry_hold_c: cover property (drv_d_reg && eff_band[0] != stable_band[0]);
endmodule : rib_top

// ==== hdl/rib_consts.svh ====
// Purpose: constants for the resistive inhibit band logic
// Assumes: 20 MHz reference clock, AXI4-Lite register access
// Notes: byte offsets and field positions of the register map
`ifndef RIB_CONSTS_SVH
`define RIB_CONSTS_SVH
// ==========================================================
// register byte offsets
`define RIB_OFF_THR_A 8'h00
`define RIB_OFF_THR_B 8'h04
`define RIB_OFF_SPD_A 8'h08
`define RIB_OFF_SPD_B 8'h0c
`define RIB_OFF_CFG 8'h10
`define RIB_OFF_ACT 8'h14
`define RIB_OFF_STAT 8'h18
// ==========================================================
// field positions and limits
`define RIB_PCT_MAX 7'h64
`define RIB_CFG_LATCH 0
`define RIB_CFG_SEAT 2
`define RIB_CFG_ALM_CHG 3
`define RIB_CFG_ALM 4
`define RIB_CFG_ENTRY 6
`define RIB_CFG_DEB 8
`define RIB_DEB_MIN 6'h01
`define RIB_DEB_MAX 6'h28
`define RIB_CFG_MASK 32'h003f_3fff
`define RIB_THR_MASK 32'h007f_7f7f
`define RIB_CFG_RST 32'h0001_0100
`define RIB_THR_RST 32'h0064_6432
`define RIB_SPD_RST 32'h6464_6464
`define RIB_ACT_RST 32'h0000_0000
`define RIB_RESP_OK 2'h0
`define RIB_RESP_ERR 2'h2
// ==========================================================
// timing
`define RIB_CLK_HZ 20000000
`define RIB_DEB_STEP_MS 100
`endif

// ==== hdl/rib_pkg.sv ====
// Purpose: shared types of the resistive inhibit band logic
// Assumes: percentages carried as 7-bit values 0..100
// Notes: constants live in rib_consts.svh
package rib_pkg;
   // ==========================================================
   // types
   typedef logic [6:0] rib_pct_t;   // measured or programmed percent
   typedef logic [1:0] rib_band_t;  // band index 0..3
   typedef enum logic [3:0] {
      RIB_B0 = 4'h1,
      RIB_B1 = 4'h2,
      RIB_B2 = 4'h4,
      RIB_B3 = 4'h8
   } rib_band_oh_t;                 // one-hot band code, unused; status holds 2-bit bands
endpackage : rib_pkg

// ==== sim/rib_pot_model.sv ====
// Purpose: resistive inhibit source, turns a resistance into the percent scale
// Assumes: full scale at ten kilohm, open circuit given as all ones
// Notes: behavioural, settles at once; one instance per inhibit input
`timescale 1ns/1ns
// ==========================================================
// switch network and potentiometer model
module rib_pot_model (
   input wire logic [15:0] ohms_i, // network resistance in ohm
   output logic [6:0] pct_o // scaled reading seen by the device
);
   // saturate so an open line reads full scale, never wraps
   always_comb begin
      if (ohms_i >= 16'h2710) begin
         pct_o = 7'h64;
      end else begin
         pct_o = 7'(ohms_i / 16'h0064);
      end
   end
endmodule : rib_pot_model

// ==== sim/resistive_inhibit_band_logic_test.sv ====
// Purpose: self-checking bench of the inhibit band logic
// Assumes: STEP_CYC of 4 so one debounce step is four clocks
// Notes: register reads checked through a queue of expected words
`timescale 1ns/1ns
`include "rib_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
// ==========================================================
// bench top
module resistive_inhibit_band_logic_test import rib_pkg::*;;
   logic ref_clk_i, arst_n_i, ce_i, charger_i, drive_active_i;
   logic [6:0] pct_a_i, pct_b_i, speed_cap_o, p;
   logic [15:0] ohm_a, ohm_b; // far-side resistances
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, thr, spd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, act_up_block_o, act_down_block_o;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic drive_inhibit_o, gauge_flash_six_o, gauge_charging_o, seat_reverse_o;
   logic fwd_rate_sel_o, alarm_o;
   int bad_count, samples_checked;
   logic [33:0] rq[$], ew; // expected {resp, data} of pending reads
   logic [6:0] tab[8] = '{7'h00, 7'h13, 7'h14, 7'h28, 7'h29, 7'h3c, 7'h3d, 7'h64};
   rib_pot_model u_pot_a (.ohms_i(ohm_a), .pct_o(pct_a_i));
   rib_pot_model u_pot_b (.ohms_i(ohm_b), .pct_o(pct_b_i));
   rib_top #(.STEP_CYC(4)) DUT (.ref_clk_i, .arst_n_i, .ce_i, .pct_a_i, .pct_b_i, .charger_i,
      .drive_active_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .speed_cap_o, .drive_inhibit_o, .gauge_flash_six_o,
      .gauge_charging_o, .seat_reverse_o, .fwd_rate_sel_o, .alarm_o, .act_up_block_o,
      .act_down_block_o);
   // own band model: below lower, up to middle, up to upper, above
   function automatic logic [1:0] bnd(input logic [6:0] v);
      if (v < thr[6:0]) return 2'h0;
      if (v <= thr[14:8]) return 2'h1;
      if (v <= thr[22:16]) return 2'h2;
      return 2'h3;
   endfunction : bnd
   // write: each half dropped at the edge it is taken, response at its edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
      s_axi_bready <= 1'b0;
      @(posedge ref_clk_i);
   endtask : wr
   // read: expected word queued, the watcher below compares
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge ref_clk_i);
   endtask : rd
   // set both inputs, then give sync plus debounce ample time
   task automatic put(input logic [6:0] a, input logic [6:0] b);
      ohm_a <= (a == 7'h64) ? 16'hffff : 16'(a) * 16'h0064;
      ohm_b <= (b == 7'h64) ? 16'hffff : 16'(b) * 16'h0064;
      repeat (40) @(posedge ref_clk_i);
   endtask : put
   task end_sim;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // ==========================================================
   // clock, read watcher, watchdog
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      if (s_axi_rvalid && s_axi_rready) begin
         ew = rq.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, ew)
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      end_sim();
   end
   // ==========================================================
   // main sequence
   initial begin
      {arst_n_i, charger_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
      {ce_i, drive_active_i, s_axi_wstrb, ohm_a, ohm_b} = 38'h3f_ffff_ffff;
      bad_count = 0;
      samples_checked = 0;
      thr = 32'h003c_2814;
      spd = 32'h281e_140a;
      void'($urandom(32'haa52));
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rd(`RIB_OFF_THR_A, {2'h0, `RIB_THR_RST});
      rd(`RIB_OFF_SPD_B, {2'h0, `RIB_SPD_RST});
      rd(`RIB_OFF_CFG, {2'h0, `RIB_CFG_RST});
      rd(`RIB_OFF_ACT, {2'h0, `RIB_ACT_RST});
      rd(8'h1c, {`RIB_RESP_ERR, 32'h0});
      wr(`RIB_OFF_STAT, 32'h0, `RIB_RESP_ERR);
      wr(`RIB_OFF_THR_A, 32'h0065_2814);
      rd(`RIB_OFF_THR_A, {2'h0, 32'h0064_2814});
      wr(`RIB_OFF_THR_A, thr);
      wr(`RIB_OFF_THR_B, thr);
      wr(`RIB_OFF_SPD_A, spd);
      for (int i = 0; i < 10; i++) begin
         p = (i < 8) ? tab[i] : 7'($urandom_range(100));
         put(p, 7'h1e);
         `CHK(speed_cap_o, spd[8*bnd(p)+:7])
      end
      wr(`RIB_OFF_SPD_B, 32'h0532_3232);
      put(7'h32, 7'h50);
      `CHK(speed_cap_o, 7'h05)
      put(7'h0a, 7'h1e);
      `CHK(speed_cap_o, 7'h0a)
      wr(`RIB_OFF_SPD_B, 32'h0032_3232);
      put(7'h32, 7'h50);
      `CHK({drive_inhibit_o, speed_cap_o, gauge_charging_o}, 9'h100)
      put(7'h32, 7'h1e);
      `CHK(drive_inhibit_o, 1'b0)
      // a two-clock bounce must not be taken as a band change
      ohm_a <= 16'h1f40;
      repeat (2) @(posedge ref_clk_i);
      ohm_a <= 16'h1388;
      repeat (4) @(posedge ref_clk_i);
      `CHK(speed_cap_o, 7'h1e)
      wr(`RIB_OFF_CFG, 32'h0001_0110);
      put(7'h32, 7'h1e);
      `CHK(alarm_o, 1'b1)
      wr(`RIB_OFF_CFG, 32'h0001_0108);
      put(7'h32, 7'h1e);
      `CHK(alarm_o, 1'b0)
      charger_i <= 1'b1;
      put(7'h32, 7'h1e);
      `CHK(alarm_o, 1'b1)
      charger_i <= 1'b0;
      wr(`RIB_OFF_CFG, 32'h0001_0104);
      put(7'h00, 7'h1e);
      `CHK({seat_reverse_o, fwd_rate_sel_o}, 2'h3)
      wr(`RIB_OFF_CFG, 32'h0001_0100);
      put(7'h00, 7'h1e);
      `CHK({seat_reverse_o, fwd_rate_sel_o}, 2'h0)
      for (int i = 0; i < 16; i++) begin
         wr(`RIB_OFF_ACT, 32'h1 << i);
         p = i[0] ? 7'h50 : 7'h0a;
         put(i[1] ? 7'h1e : p, i[1] ? p : 7'h1e);
         `CHK({act_down_block_o, act_up_block_o}, 4'h1 << (2 * i[2] + i[3]))
      end
      wr(`RIB_OFF_ACT, 32'h0000_ffff);
      put(7'h32, 7'h1e);
      `CHK({act_down_block_o, act_up_block_o}, 4'h0)
      wr(`RIB_OFF_SPD_A, 32'h001e_140a);
      wr(`RIB_OFF_CFG, 32'h0001_0103);
      put(7'h50, 7'h1e);
      `CHK({drive_inhibit_o, gauge_flash_six_o}, 2'h3)
      put(7'h0a, 7'h1e);
      `CHK({drive_inhibit_o, gauge_flash_six_o}, 2'h3)
      put(7'h0a, 7'h50);
      `CHK(gauge_charging_o, 1'b1)
      // power cycle clears the latched trips
      arst_n_i <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      put(7'h0a, 7'h1e);
      `CHK({drive_inhibit_o, gauge_flash_six_o, gauge_charging_o}, 3'h0)
      wr(`RIB_OFF_SPD_A, spd);
      wr(`RIB_OFF_CFG, 32'h0001_0140);
      put(7'h64, 7'h1e);
      `CHK(speed_cap_o, 7'h0a)
      drive_active_i <= 1'b0;
      put(7'h64, 7'h1e);
      `CHK(speed_cap_o, 7'h14)
      end_sim();
   end
endmodule : resistive_inhibit_band_logic_test
